// ===== tccp_timer.v
// Timer core: 16-bit counter with capture, compare and PWM channels.
// What this block does
// R1: Sixteen-bit counter with up to four channels.
// R2: Each channel picks capture, compare or PWM.
// R3: Capture copies counter into buffer on event.
// R4: Compare output follows counter versus threshold.
// R5: PWM waveform follows successive compare values written.
// R6: Dead-time insertion only when HAS_DTI is nonzero, in PWM mode.
// R7: Counts events and emits triggers to signal network.
// R8: Enabled counter steps by one, wraps at max.
`timescale 1ns/1ps
`include "tccp_defines.vh"
module tccp_timer #(
  parameter NCH        = 4,
  parameter HAS_DTI    = 0
) (
  // Clock and reset
  input  wire                       core_clk,
  input  wire                       rst_b,
  // Counter control
  input  wire                       cnt_enable,
  input  wire                       cnt_source,
  input  wire                       cnt_event,
  // Channel configuration
  input  wire [NCH*2-1:0]           ch_mode,
  input  wire [NCH*2-1:0]           ch_edge,
  input  wire [NCH*16-1:0]          ch_compare,
  input  wire [NCH-1:0]             ch_compare_load,
  input  wire [`TCCP_DT_W-1:0]      dead_time,
  // Channel pins and results
  input  wire [NCH-1:0]             ch_in,
  output wire [NCH-1:0]             ch_out,
  output wire [NCH-1:0]             ch_out_comp,
  output wire [NCH*16-1:0]          ch_capture,
  output wire [NCH-1:0]             ch_capture_valid,
  // Counter state and network triggers
  output reg  [`TCCP_CNT_W-1:0]     count,
  output reg                        overflow_trig,
  output wire [NCH-1:0]             peripheral_signal_network
);

  localparam CW  = `TCCP_CNT_W;
  localparam MW  = `TCCP_MODE_W;
  localparam SW  = `TCCP_SYNC_W;
  localparam DTW = `TCCP_DT_W;

  reg  [SW-1:0]  event_sync;
  reg            event_prev;
  wire           event_rise;
  wire           step;
  wire           wrap;
  reg  [CW-1:0]  next_count;

  assign event_rise = event_sync[SW-1] & ~event_prev;
  assign step       = cnt_enable & ((cnt_source == `TCCP_SRC_CLOCK) | event_rise); // R7
  assign wrap       = step & (count == `TCCP_CNT_MAX);

  // Next counter value: one step up, back to zero after the top value.
  always @* begin
    if (wrap) begin
      next_count = `TCCP_CNT_ZERO; // R8
    end else if (step) begin
      next_count = count + `TCCP_CNT_ONE; // R8
    end else begin
      next_count = count;
    end
  end

  // The event line is asynchronous, so only the second flop feeds the edge detector.
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_sync <= {SW{1'b0}};
      event_prev <= 1'b0;
    end else begin
      event_sync <= {event_sync[SW-2:0], cnt_event};
      event_prev <= event_sync[SW-1];
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count         <= `TCCP_CNT_ZERO;
      overflow_trig <= 1'b0;
    end else begin
      count         <= next_count; // R1
      overflow_trig <= wrap; // R7
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      wire [MW-1:0]  mode;
      wire [MW-1:0]  edge_sel;
      wire [CW-1:0]  cmp_value;
      reg  [SW-1:0]  in_sync;
      reg            in_prev;
      wire           rise;
      wire           fall;
      reg            hit;
      reg  [CW-1:0]  thresh;
      wire           load_ok;
      wire           match;
      reg            raw;
      reg            next_raw;
      reg  [DTW-1:0] dt_cnt;
      reg            out_q;
      reg            comp_q;
      reg  [CW-1:0]  cap_q;
      reg            cap_valid_q;
      reg            trig_q;

      assign mode      = ch_mode[i*MW +: MW];
      assign edge_sel  = ch_edge[i*MW +: MW];
      assign cmp_value = ch_compare[i*CW +: CW];
      assign rise      = in_sync[SW-1] & ~in_prev;
      assign fall      = ~in_sync[SW-1] & in_prev;
      assign match     = (count == thresh);
      // PWM takes new values only at wrap or while stopped so each period stays whole.
      assign load_ok   = (mode != `TCCP_MODE_PWM) | wrap | ~cnt_enable; // R5

      always @* begin
        case (edge_sel)
          `TCCP_EDGE_RISE: hit = rise;
          `TCCP_EDGE_FALL: hit = fall;
          `TCCP_EDGE_BOTH: hit = rise | fall;
          default:         hit = 1'b0;
        endcase
      end

      always @* begin
        case (mode) // R2
          `TCCP_MODE_COMPARE: next_raw = (count >= thresh); // R4
          `TCCP_MODE_PWM:     next_raw = (count < thresh); // R5
          default:            next_raw = 1'b0;
        endcase
      end

      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          in_sync <= {SW{1'b0}};
          in_prev <= 1'b0;
        end else begin
          in_sync <= {in_sync[SW-2:0], ch_in[i]};
          in_prev <= in_sync[SW-1];
        end
      end

      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          thresh <= `TCCP_CNT_ZERO;
        end else if (ch_compare_load[i] && load_ok) begin
          thresh <= cmp_value; // R4
        end
      end

      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          cap_q       <= `TCCP_CNT_ZERO;
          cap_valid_q <= 1'b0;
        end else begin
          cap_valid_q <= 1'b0;
          if (mode == `TCCP_MODE_CAPTURE && hit) begin
            cap_q       <= count; // R3
            cap_valid_q <= 1'b1;
          end
        end
      end

      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          trig_q <= 1'b0;
        end else if (mode == `TCCP_MODE_CAPTURE) begin
          trig_q <= hit; // R7
        end else begin
          trig_q <= (mode != `TCCP_MODE_OFF) & step & match; // R7
        end
      end

      // Both outputs go low while the dead-time counter runs after an edge.
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          raw    <= 1'b0;
          dt_cnt <= {DTW{1'b0}};
          out_q  <= 1'b0;
          comp_q <= 1'b0;
        end else begin
          raw <= next_raw;
          if (HAS_DTI != 0 && mode == `TCCP_MODE_PWM) begin
            if (raw != next_raw) begin
              dt_cnt <= dead_time; // R6
              out_q  <= 1'b0;
              comp_q <= 1'b0;
            end else if (dt_cnt != {DTW{1'b0}}) begin
              dt_cnt <= dt_cnt - {{(DTW-1){1'b0}}, 1'b1};
            end else begin
              out_q  <= raw;
              comp_q <= ~raw;
            end
          end else begin
            dt_cnt <= {DTW{1'b0}};
            out_q  <= raw;
            comp_q <= 1'b0; // R6
          end
        end
      end

      assign ch_out[i]                    = out_q;
      assign ch_out_comp[i]               = comp_q;
      assign ch_capture[i*CW +: CW]       = cap_q;
      assign ch_capture_valid[i]          = cap_valid_q;
      assign peripheral_signal_network[i] = trig_q;

    end
  endgenerate

endmodule

// ===== tccp_defines.vh
// Constants for the timer with capture, compare and PWM channels.
`ifndef TCCP_DEFINES_VH
`define TCCP_DEFINES_VH
`define TCCP_CNT_W        16
`define TCCP_CNT_MAX      16'hffff
`define TCCP_CNT_ZERO     16'h0000
`define TCCP_CNT_ONE      16'h0001
`define TCCP_SYNC_W       2
`define TCCP_MODE_W       2
`define TCCP_MODE_OFF     2'h0
`define TCCP_MODE_CAPTURE 2'h1
`define TCCP_MODE_COMPARE 2'h2
`define TCCP_MODE_PWM     2'h3
`define TCCP_EDGE_RISE    2'h1
`define TCCP_EDGE_FALL    2'h2
`define TCCP_EDGE_BOTH    2'h3
`define TCCP_SRC_CLOCK    1'b0
`define TCCP_SRC_EVENT    1'b1
`define TCCP_DT_W         8
`endif

// ===== tccp_timer_chk.sv
// Assertion checker on the timer ports.
`timescale 1ns/1ps
module tccp_timer_chk #(parameter NCH = 4) (
  // Clock, reset and counter control
  input wire             core_clk, rst_b, cnt_enable, cnt_source, cnt_event,
  // Counter state and channel results
  input wire             overflow_trig,
  input wire [15:0]      count,
  input wire [NCH*16-1:0] ch_capture,
  input wire [NCH-1:0]   ch_capture_valid, ch_out_comp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_count_step: assert property ($past(rst_b) && $past(cnt_enable) && !$past(cnt_source)
    |-> count == $past(count) + 16'h1) else $error("count did not step by one");
  chk_count_hold: assert property ($past(rst_b) && !$past(cnt_enable) |-> $stable(count))
    else $error("count moved while disabled");
  chk_wrap_trig: assert property ($past(rst_b) |-> overflow_trig ==
    ($past(count) == 16'hffff && count == 16'h0)) else $error("bad wrap trigger");
  chk_trig_pulse: assert property (overflow_trig |=> !overflow_trig)
    else $error("wrap trigger longer than a cycle");
  chk_valid_pulse: assert property (ch_capture_valid[0] |=> !ch_capture_valid[0])
    else $error("capture valid longer than a cycle");
  chk_cap_stable: assert property (!ch_capture_valid[0] |-> $stable(ch_capture[15:0]))
    else $error("capture buffer changed without a capture");
  chk_no_dead_time: assert property (ch_out_comp == '0)
    else $error("complementary output active without dead-time logic");
  chk_event_idle: assert property ((cnt_enable && cnt_source && !cnt_event) [*4]
    |=> $stable(count)) else $error("count moved with no event");
endmodule
bind tccp_timer tccp_timer_chk #(.NCH(NCH)) chk (.core_clk, .rst_b, .cnt_enable, .cnt_source,
  .cnt_event, .overflow_trig, .count, .ch_capture, .ch_capture_valid, .ch_out_comp);

// ===== tccp_pulse_src.sv
// Far-side source of two-cycle pulses on a channel pin or the event line.
`timescale 1ns/1ps
module tccp_pulse_src (
  // Clock and request
  input  wire core_clk,
  input  wire fire,
  // Driven line
  output reg  line = 1'b0
);
  reg left = 1'b0;
  always @(posedge core_clk) begin
    if (fire) begin
      line <= 1'b1;
      left <= 1'b1;
    end else if (left) begin
      left <= 1'b0;
    end else begin
      line <= 1'b0;
    end
  end
endmodule

// ===== tb_timer_capture_compare_pwm.sv
// Self-checking bench for the timer with capture, compare and PWM channels.
`timescale 1ns/1ps
module tb_timer_capture_compare_pwm;
  reg core_clk = 0, rst_b = 0, cnt_enable = 0, cnt_source = 0, fire_cap = 0, fire_evt = 0;
  reg  [7:0]  ch_mode = 8'hf9, ch_edge = 8'h01;
  reg  [63:0] ch_compare = 64'h0004_0008_0008_0000;
  wire        cnt_event, cap_pin, overflow_trig;
  wire [3:0]  ch_out, ch_capture_valid, ch_out_comp, psn;
  wire [63:0] ch_capture;
  wire [15:0] count;
  integer     failures = 0, cmp_count = 0, nv = 0, nt = 0, np = 0;
  reg  [15:0] exp_cnt = 16'h0;
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    nv = nv + ch_capture_valid[0];
    nt = nt + overflow_trig;
    np = np + psn[0];
  end
  tccp_pulse_src cap (.core_clk(core_clk), .fire(fire_cap), .line(cap_pin));
  tccp_pulse_src evt (.core_clk(core_clk), .fire(fire_evt), .line(cnt_event));
  tccp_timer dut (.core_clk(core_clk), .rst_b(rst_b), .cnt_enable(cnt_enable),
    .cnt_source(cnt_source), .cnt_event(cnt_event), .ch_mode(ch_mode), .ch_edge(ch_edge),
    .ch_compare(ch_compare), .ch_compare_load(4'hf), .dead_time(8'h00), .ch_in({3'h0, cap_pin}),
    .ch_out(ch_out), .ch_out_comp(ch_out_comp), .ch_capture(ch_capture),
    .ch_capture_valid(ch_capture_valid), .count(count), .overflow_trig(overflow_trig),
    .peripheral_signal_network(psn));
  task ck(input [15:0] got, input [15:0] want);
    begin
      cmp_count = cmp_count + 1;
      if (got !== want) begin
        failures = failures + 1;
        $display("Error %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task settle;
    begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask
  task run(input integer n);
    begin
      @(posedge core_clk) cnt_enable <= 1'b1;
      repeat (n) @(posedge core_clk);
      cnt_enable <= 1'b0;
      exp_cnt = exp_cnt + n;
      settle;
      ck(count, exp_cnt);
    end
  endtask
  task t_compare_pwm;
    begin
      settle;
      ck(ch_out_comp, 0);
      ck(ch_out[1], 0);
      ck(ch_out[2], 1);
      run(8);
      ck(ch_out[1], 1);
      ck(ch_out[2], 0);
      ck(ch_out[3], 0);
      @(posedge core_clk) ch_compare[63:48] <= 16'h0100;
      settle;
      ck(ch_out[3], 1);
      @(posedge core_clk) ch_mode[3:2] <= 2'h0;
      settle;
      ck(ch_out[1], 0);
    end
  endtask
  task t_capture;
    begin
      @(posedge core_clk) fire_cap <= 1'b1;
      @(posedge core_clk) fire_cap <= 1'b0;
      settle;
      ck(ch_capture[15:0], exp_cnt);
      ck(nv, 1);
      ck(np, 1);
      @(posedge core_clk) fire_cap <= 1'b1;
      ch_edge[1:0] <= 2'h3;
      @(posedge core_clk) fire_cap <= 1'b0;
      settle;
      ck(nv, 3);
      ck(np, 3);
      ck(ch_capture[15:0], exp_cnt);
    end
  endtask
  task t_events;
    integer i;
    begin
      @(posedge core_clk) cnt_source <= 1'b1;
      cnt_enable <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        fire_evt <= 1'b1;
        @(posedge core_clk) fire_evt <= 1'b0;
        repeat (5) @(posedge core_clk);
      end
      cnt_enable <= 1'b0;
      cnt_source <= 1'b0;
      exp_cnt = exp_cnt + 3;
      settle;
      ck(count, exp_cnt);
    end
  endtask
  task t_wrap;
    begin
      run(16'hffff - exp_cnt + 3);
      ck(nt, 1);
    end
  endtask
  task conclude;
    begin
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #10000000;
    failures = failures + 1;
    conclude;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    t_compare_pwm;
    t_capture;
    t_events;
    t_wrap;
    conclude;
  end
endmodule
